// >>> core/fsb_cpu_end.sv
// Processor end: link sampling, strobed data capture and low-power states
//
// Contract
// - Agent asserts deferral for out-of-order completion
// - Addressed memory or I/O agent drives deferral
// - Deep Sleep to Deeper on deeper request
// - Deeper request released returns to Deep Sleep
// - Sleep to Deep Sleep on deep request
// - Deep request released returns to Sleep
// - Deep and Deeper Sleep optional by parameter
// - Data driver asserts data-ready every transfer
// - Idle clocks without data-ready capture nothing
`timescale 1ns/100ps
`default_nettype none

// ********************************
// Two-stage synchroniser
// ********************************
module fsb_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second; reset to pin idle levels so no false edge follows reset
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_r <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule

module fsb_cpu_end #(
    parameter bit DEEP_EN = 1'b1,
    parameter bit DEEPER_EN = 1'b1
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    fsb_link_if.cpu link,
    input wire logic sleep_req_in,
    output logic [fsb_pkg::DATA_W-1:0] word_out,
    output logic word_valid_out,
    output logic deferred_out,
    output logic [3:0] power_state_out
);
    localparam int SW = fsb_pkg::DATA_W + 3 * fsb_pkg::GRPS + 5;

    // ********************************
    // Pin sampling
    // ********************************
    logic [SW-1:0] pins_s;
    wire logic [SW-1:0] pins_raw = {link.bus_clk, link.n_a_n,
        link.deep_sleep_req_n, link.deeper_sleep_req_n, link.data_valid_n,
        link.data_strobe_pos_n, link.data_strobe_neg_n, link.data_invert_n,
        link.data_n};

    // Link pins are asynchronous to the core clock; bus clock idles low, all else high
    fsb_sync2 #(
        .W(SW),
        .RST_VAL({1'b0, {(SW - 1){1'b1}}})
    ) u_sync (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .d_in(pins_raw),
        .q_out(pins_s)
    );

    // Field split of the sampled vector
    wire logic bclk_s = pins_s[SW-1];
    wire logic n_a_n_s = pins_s[SW-2];
    wire logic deep_n_s = pins_s[SW-3];
    wire logic deeper_n_s = pins_s[SW-4];
    wire logic valid_n_s = pins_s[SW-5];
    wire logic [fsb_pkg::GRPS-1:0] pos_n_s = pins_s[fsb_pkg::DATA_W + 8 +: 4];
    wire logic [fsb_pkg::GRPS-1:0] neg_n_s = pins_s[fsb_pkg::DATA_W + 4 +: 4];
    wire logic [fsb_pkg::GRPS-1:0] inv_n_s = pins_s[fsb_pkg::DATA_W +: 4];
    wire logic [fsb_pkg::DATA_W-1:0] data_n_s = pins_s[fsb_pkg::DATA_W-1:0];

    // ********************************
    // Edge detection
    // ********************************
    logic bclk_d_r;
    logic [fsb_pkg::GRPS-1:0] pos_d_r;
    logic [fsb_pkg::GRPS-1:0] neg_d_r;

    // Previous levels taken from the synchronised copies only
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            bclk_d_r <= 1'b0;
            pos_d_r <= fsb_pkg::GRP_IDLE;
            neg_d_r <= fsb_pkg::GRP_IDLE;
        end else begin
            bclk_d_r <= bclk_s;
            pos_d_r <= pos_n_s;
            neg_d_r <= neg_n_s;
        end
    end

    wire logic bclk_rise = bclk_s && !bclk_d_r;
    wire logic [fsb_pkg::GRPS-1:0] pos_fall = pos_d_r & ~pos_n_s;
    wire logic [fsb_pkg::GRPS-1:0] neg_fall = neg_d_r & ~neg_n_s;
    wire logic data_live = !valid_n_s;

    // ********************************
    // Per-group capture
    // ********************************
    logic [fsb_pkg::GRPS-1:0] pos_seen_r;
    logic [fsb_pkg::GRPS-1:0] got_r;
    logic [fsb_pkg::DATA_W-1:0] asm_r;
    logic [fsb_pkg::GRPS-1:0] pos_seen_nxt;
    logic [fsb_pkg::GRPS-1:0] got_nxt;
    logic [fsb_pkg::GRPS-1:0] latch;
    logic [fsb_pkg::DATA_W-1:0] asm_nxt;
    logic [fsb_pkg::DATA_W-1:0] dec;

    // Undo pin polarity and group inversion
    always_comb begin
        for (int n = 0; n < fsb_pkg::GRPS; n++) begin
            dec[n*fsb_pkg::GRP_W +: fsb_pkg::GRP_W] = inv_n_s[n] ?
                ~data_n_s[n*fsb_pkg::GRP_W +: fsb_pkg::GRP_W] :
                data_n_s[n*fsb_pkg::GRP_W +: fsb_pkg::GRP_W];
        end
    end

    // A group latches on its neg strobe only after its pos strobe went
    // by in the same transfer; strobes without data-ready are dropped
    always_comb begin
        latch = neg_fall & pos_seen_r & {fsb_pkg::GRPS{data_live}};
        pos_seen_nxt = (pos_seen_r & ~latch) | (pos_fall & {fsb_pkg::GRPS{data_live}});
        got_nxt = got_r | latch;
        asm_nxt = asm_r;
        for (int n = 0; n < fsb_pkg::GRPS; n++) begin
            if (latch[n]) begin
                asm_nxt[n*fsb_pkg::GRP_W +: fsb_pkg::GRP_W] = dec[n*fsb_pkg::GRP_W +: fsb_pkg::GRP_W];
            end
        end
    end

    wire logic word_done = &got_nxt;

    // Assembly state; a finished word restarts the group tracking
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pos_seen_r <= 4'h0;
            got_r <= 4'h0;
            asm_r <= '0;
        end else begin
            pos_seen_r <= pos_seen_nxt;
            got_r <= word_done ? 4'h0 : got_nxt;
            asm_r <= asm_nxt;
        end
    end

    // ********************************
    // Word output
    // ********************************
    logic [fsb_pkg::DATA_W-1:0] word_r;
    logic word_valid_r;

    // One-cycle pulse per complete four-group word
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            word_r <= '0;
            word_valid_r <= 1'b0;
        end else begin
            word_valid_r <= word_done;
            if (word_done) begin
                word_r <= asm_nxt;
            end
        end
    end

    // ********************************
    // Deferral flag
    // ********************************
    logic deferred_r;

    // Sampled at bus clock rise, as a bus agent would see it
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            deferred_r <= 1'b0;
        end else if (bclk_rise) begin
            deferred_r <= !n_a_n_s;
        end
    end

    // ********************************
    // Low-power state machine
    // ********************************
    fsb_pkg::fsb_pstate_t ps_r;
    fsb_pkg::fsb_pstate_t ps_nxt;
    wire logic deep_req = !deep_n_s && DEEP_EN;
    wire logic deeper_req = !deeper_n_s && DEEPER_EN && DEEP_EN;

    // Steps only to neighbours; a request in the wrong state is ignored
    always_comb begin
        ps_nxt = ps_r;
        unique case (ps_r)
            fsb_pkg::PS_AWAKE: begin
                if (sleep_req_in) begin
                    ps_nxt = fsb_pkg::PS_SLEEP;
                end
            end
            fsb_pkg::PS_SLEEP: begin
                if (deep_req) begin
                    ps_nxt = fsb_pkg::PS_DEEP;
                end else if (!sleep_req_in) begin
                    ps_nxt = fsb_pkg::PS_AWAKE;
                end
            end
            fsb_pkg::PS_DEEP: begin
                if (!deep_req) begin
                    ps_nxt = fsb_pkg::PS_SLEEP;
                end else if (deeper_req) begin
                    ps_nxt = fsb_pkg::PS_DEEPER;
                end
            end
            fsb_pkg::PS_DEEPER: begin
                if (!deeper_req) begin
                    ps_nxt = fsb_pkg::PS_DEEP;
                end
            end
            default: begin
                ps_nxt = fsb_pkg::PS_AWAKE;
            end
        endcase
    end

    // Stepped at bus clock rise so one step per bus clock at most
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ps_r <= fsb_pkg::PS_AWAKE;
        end else if (bclk_rise) begin
            ps_r <= ps_nxt;
        end
    end

    assign word_out = word_r;
    assign word_valid_out = word_valid_r;
    assign deferred_out = deferred_r;
    assign power_state_out = ps_r;
endmodule
`default_nettype wire

// >>> core/fsb_pkg.sv
// Shared constants and types for the front-side data phase and sleep link
package fsb_pkg;
    // ********************************
    // Link geometry
    // ********************************
    localparam int DATA_W = 64;
    localparam int GRP_W = 16;
    localparam int GRPS = 4;
    localparam int MAJ_LIMIT = 8;
    // ********************************
    // Timing
    // ********************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int BUS_HALF_NS = 60;
    localparam int BUS_HALF_CYC = (BUS_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUF_DEPTH = 2;
    // ********************************
    // Reset values
    // ********************************
    localparam logic [DATA_W-1:0] DATA_IDLE = 64'hffff_ffff_ffff_ffff;
    localparam logic [GRPS-1:0] GRP_IDLE = 4'hf;
    // ********************************
    // Low-power states
    // ********************************
    typedef enum logic [3:0] {
        PS_AWAKE = 4'h1,
        PS_SLEEP = 4'h2,
        PS_DEEP = 4'h4,
        PS_DEEPER = 4'h8
    } fsb_pstate_t;
endpackage

// >>> core/fsb_link_if.sv
// Link between the processor end and the chipset end
`timescale 1ns/100ps
`default_nettype none
interface fsb_link_if;
    logic bus_clk;
    logic n_a_n;
    logic deep_sleep_req_n;
    logic deeper_sleep_req_n;
    logic data_valid_n;
    logic [fsb_pkg::DATA_W-1:0] data_n;
    logic [fsb_pkg::GRPS-1:0] data_invert_n;
    logic [fsb_pkg::GRPS-1:0] data_strobe_pos_n;
    logic [fsb_pkg::GRPS-1:0] data_strobe_neg_n;
    // Chipset drives everything in this build
    modport hub (output bus_clk, n_a_n, deep_sleep_req_n, deeper_sleep_req_n,
        data_valid_n, data_n, data_invert_n, data_strobe_pos_n, data_strobe_neg_n);
    modport cpu (input bus_clk, n_a_n, deep_sleep_req_n, deeper_sleep_req_n,
        data_valid_n, data_n, data_invert_n, data_strobe_pos_n, data_strobe_neg_n);
endinterface
`default_nettype wire

// >>> core/fsb_hub_end.sv
// Chipset end: bus clock divider, send buffer, strobe and sleep request drive
`timescale 1ns/100ps
`default_nettype none
module fsb_hub_end #(
    parameter int HALF_CYC = fsb_pkg::BUS_HALF_CYC
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    fsb_link_if.hub link,
    input wire logic [fsb_pkg::DATA_W-1:0] word_in,
    input wire logic word_valid_in,
    output logic word_ready_out,
    input wire logic n_a_in,
    input wire logic deep_sleep_in,
    input wire logic deeper_sleep_in
);
    // ********************************
    // Inversion encoding
    // ********************************
    // Invert a group when more than half its pins would be low
    function automatic logic want_inv(input logic [fsb_pkg::GRP_W-1:0] g);
        int ones;
        ones = 0;
        for (int i = 0; i < fsb_pkg::GRP_W; i++) begin
            ones = ones + int'(g[i]);
        end
        return ones > fsb_pkg::MAJ_LIMIT;
    endfunction

    // ********************************
    // Bus clock divider
    // ********************************
    logic [7:0] div_r;
    logic bus_clk_r;
    wire logic div_end = (div_r == 8'(HALF_CYC - 1));
    wire logic rise_tick = div_end && !bus_clk_r;
    wire logic fall_tick = div_end && bus_clk_r;

    // Free-running so the processor end always sees edges
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            div_r <= 8'h00;
            bus_clk_r <= 1'b0;
        end else begin
            div_r <= div_end ? 8'h00 : div_r + 8'h01;
            if (div_end) begin
                bus_clk_r <= !bus_clk_r;
            end
        end
    end

    // ********************************
    // Two-entry send buffer
    // ********************************
    logic [fsb_pkg::DATA_W-1:0] buf_r [fsb_pkg::BUF_DEPTH];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] cnt_r;
    logic ready_r;
    wire logic push = word_valid_in && ready_r;
    wire logic pop = rise_tick && (cnt_r != 2'h0);
    wire logic [1:0] cnt_nxt = cnt_r + 2'(push) - 2'(pop);
    wire logic [fsb_pkg::DATA_W-1:0] head = buf_r[rd_ptr_r];

    // Drains only one word per bus clock, so a slow link stalls the user
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            cnt_r <= 2'h0;
            ready_r <= 1'b0;
        end else begin
            wr_ptr_r <= wr_ptr_r ^ push;
            rd_ptr_r <= rd_ptr_r ^ pop;
            cnt_r <= cnt_nxt;
            ready_r <= (cnt_nxt != 2'(fsb_pkg::BUF_DEPTH));
        end
    end

    // Storage has no reset
    always_ff @(posedge core_clk_in) begin
        if (push) begin
            buf_r[wr_ptr_r] <= word_in;
        end
    end

    // ********************************
    // Data phase drive
    // ********************************
    logic [fsb_pkg::DATA_W-1:0] data_n_r;
    logic [fsb_pkg::GRPS-1:0] inv_n_r;
    logic [fsb_pkg::GRPS-1:0] pos_n_r;
    logic [fsb_pkg::GRPS-1:0] neg_n_r;
    logic valid_n_r;
    logic [fsb_pkg::DATA_W-1:0] enc_n;
    logic [fsb_pkg::GRPS-1:0] enc_inv_n;

    // Active-low pins: plain group drives ~g, inverted group drives g
    always_comb begin
        for (int n = 0; n < fsb_pkg::GRPS; n++) begin
            enc_inv_n[n] = !want_inv(head[n*fsb_pkg::GRP_W +: fsb_pkg::GRP_W]);
            enc_n[n*fsb_pkg::GRP_W +: fsb_pkg::GRP_W] = enc_inv_n[n] ?
                ~head[n*fsb_pkg::GRP_W +: fsb_pkg::GRP_W] : head[n*fsb_pkg::GRP_W +: fsb_pkg::GRP_W];
        end
    end

    // Word on rise with pos strobes, neg strobes on fall; empty buffer idles
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            data_n_r <= fsb_pkg::DATA_IDLE;
            inv_n_r <= fsb_pkg::GRP_IDLE;
            pos_n_r <= fsb_pkg::GRP_IDLE;
            neg_n_r <= fsb_pkg::GRP_IDLE;
            valid_n_r <= 1'b1;
        end else if (rise_tick) begin
            valid_n_r <= !pop;
            neg_n_r <= fsb_pkg::GRP_IDLE;
            pos_n_r <= pop ? 4'h0 : fsb_pkg::GRP_IDLE;
            if (pop) begin
                data_n_r <= enc_n;
                inv_n_r <= enc_inv_n;
            end
        end else if (fall_tick && !valid_n_r) begin
            pos_n_r <= fsb_pkg::GRP_IDLE;
            neg_n_r <= 4'h0;
        end
    end

    // ********************************
    // Deferral and sleep requests
    // ********************************
    logic n_a_n_r;
    logic deep_n_r;
    logic deeper_n_r;

    // Platform levels, registered before the pins
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            n_a_n_r <= 1'b1;
            deep_n_r <= 1'b1;
            deeper_n_r <= 1'b1;
        end else begin
            n_a_n_r <= !n_a_in;
            deep_n_r <= !deep_sleep_in;
            deeper_n_r <= !deeper_sleep_in;
        end
    end

    assign link.bus_clk = bus_clk_r;
    assign link.n_a_n = n_a_n_r;
    assign link.deep_sleep_req_n = deep_n_r;
    assign link.deeper_sleep_req_n = deeper_n_r;
    assign link.data_valid_n = valid_n_r;
    assign link.data_n = data_n_r;
    assign link.data_invert_n = inv_n_r;
    assign link.data_strobe_pos_n = pos_n_r;
    assign link.data_strobe_neg_n = neg_n_r;
    assign word_ready_out = ready_r;
endmodule
`default_nettype wire

// >>> verif/fsb_link_assertions.sv
// Concurrent checks on the chipset to processor link
`timescale 1ns/100ps
`default_nettype none
module fsb_link_assertions #(
    parameter int HALF_CYC = 2
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic bus_clk,
    input wire logic data_valid_n,
    input wire logic [fsb_pkg::DATA_W-1:0] data_n,
    input wire logic [fsb_pkg::GRPS-1:0] data_invert_n,
    input wire logic [fsb_pkg::GRPS-1:0] data_strobe_pos_n,
    input wire logic [fsb_pkg::GRPS-1:0] data_strobe_neg_n
);
    // ********************************
    // Bus clock half-period counter
    // ********************************
    logic bus_clk_q_r;
    logic seen_r;
    logic [7:0] hold_cnt_r;
    logic [7:0] hold_cnt_nxt;
    logic clk_moved;
    // Edge of the divided clock, seen one core cycle late
    assign clk_moved = bus_clk != bus_clk_q_r;
    assign hold_cnt_nxt = clk_moved ? 8'h00 : hold_cnt_r + 8'h01;
    // Count only from the first edge, as the divider phase at release is free
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            bus_clk_q_r <= 1'b0;
            hold_cnt_r <= 8'h00;
            seen_r <= 1'b0;
        end else begin
            bus_clk_q_r <= bus_clk;
            hold_cnt_r <= hold_cnt_nxt;
            seen_r <= seen_r | clk_moved;
        end
    end
    // ********************************
    // Link properties
    // ********************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    chk_pos_first_half: assert property (bus_clk && !data_valid_n |->
        data_strobe_pos_n == 4'h0 && data_strobe_neg_n == 4'hf)
        else $error("positive strobes wrong in first half");
    chk_neg_second_half: assert property (!bus_clk && !data_valid_n |->
        data_strobe_neg_n == 4'h0 && data_strobe_pos_n == 4'hf)
        else $error("negative strobes wrong in second half");
    chk_idle_strobes_quiet: assert property (data_valid_n |-> data_strobe_pos_n == 4'hf && data_strobe_neg_n == 4'hf)
        else $error("strobe moved while data not ready");
    chk_neg_after_pos: assert property (data_strobe_neg_n == 4'h0 && $past(data_strobe_neg_n) == 4'hf |->
        $past(data_strobe_pos_n) == 4'h0)
        else $error("negative strobe without positive before it");
    chk_data_held: assert property (!data_valid_n && !$rose(bus_clk) |-> $stable(data_n) && $stable(data_invert_n))
        else $error("data moved inside a transfer");
    chk_ready_on_rise: assert property ($changed(data_valid_n) |-> $rose(bus_clk))
        else $error("data ready changed off a bus clock rise");
    chk_clk_half_exact: assert property (clk_moved && seen_r |-> hold_cnt_r == 8'(HALF_CYC - 1))
        else $error("bus clock half period wrong");
    chk_clk_half_bound: assert property (seen_r |-> hold_cnt_r < 8'(HALF_CYC))
        else $error("bus clock stopped");
endmodule
`default_nettype wire

// >>> verif/host_bus_data_phase_and_sleep_pins_tb_top.sv
// Self-checking bench: chipset end and processor end joined by the link
`timescale 1ns/100ps
`default_nettype none
`define CHECK(name, exp, got) begin compares++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected %s expected %h seen %h", name, exp, got); end end
module host_bus_data_phase_and_sleep_pins_tb_top;
    // Short bus clock keeps the run brief; the settle wait of each pin step derives from it
    localparam int HC = 2;
    localparam int SETTLE = 3 * (2 * HC + 4);
    localparam logic [63:0] CORNER [0:3] = '{64'h0, 64'hffff_ffff_ffff_ffff,
        64'h00ff_01ff_ff00_ff80, 64'h8000_0001_7fff_fffe};
    // Pins {sleep, deep, deeper, n_a} per step and the state to reach
    localparam logic [3:0] PIN_TAB [0:6] = '{4'h2, 4'ha, 4'hc, 4'he, 4'hc, 4'h9, 4'h0};
    localparam logic [3:0] PWR_TAB [0:6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h4, 4'h2, 4'h1};
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [fsb_pkg::DATA_W-1:0] word_in = 64'h0;
    logic word_valid_in = 1'b0;
    logic n_a_in = 1'b0;
    logic deep_sleep_in = 1'b0;
    logic deeper_sleep_in = 1'b0;
    logic sleep_req_in = 1'b0;
    logic word_ready_out, word_valid_out, deferred_out;
    logic [fsb_pkg::DATA_W-1:0] word_out;
    logic [3:0] power_state_out, pwr_min, pwr_mid;
    logic [31:0] seed = 32'h6ee1;
    logic [3:0] prev_pos = 4'hf;
    logic [63:0] exp_q[$];
    logic [63:0] wire_q[$];
    int mismatches = 0;
    int compares = 0;
    // ********************************
    // Design ends, link and checker
    // ********************************
    fsb_link_if link ();
    fsb_hub_end #(.HALF_CYC(HC)) i_fsb_hub_end (.core_clk_in(core_clk_in), .reset_in(reset_in), .link(link.hub),
        .word_in(word_in), .word_valid_in(word_valid_in), .word_ready_out(word_ready_out), .n_a_in(n_a_in),
        .deep_sleep_in(deep_sleep_in), .deeper_sleep_in(deeper_sleep_in));
    fsb_cpu_end i_fsb_cpu_end (.core_clk_in(core_clk_in), .reset_in(reset_in), .link(link.cpu),
        .sleep_req_in(sleep_req_in), .word_out(word_out), .word_valid_out(word_valid_out),
        .deferred_out(deferred_out), .power_state_out(power_state_out));
    // Build without the deeper states, watching the same link
    fsb_cpu_end #(.DEEP_EN(1'b0), .DEEPER_EN(1'b0)) i_fsb_cpu_end_lite (.core_clk_in(core_clk_in),
        .reset_in(reset_in), .link(link.cpu), .sleep_req_in(sleep_req_in), .word_out(), .word_valid_out(),
        .deferred_out(), .power_state_out(pwr_min));
    // Build with Deep Sleep but without Deeper Sleep
    fsb_cpu_end #(.DEEP_EN(1'b1), .DEEPER_EN(1'b0)) i_fsb_cpu_end_mid (.core_clk_in(core_clk_in),
        .reset_in(reset_in), .link(link.cpu), .sleep_req_in(sleep_req_in), .word_out(), .word_valid_out(),
        .deferred_out(), .power_state_out(pwr_mid));
    fsb_link_assertions #(.HALF_CYC(HC)) i_fsb_link_assertions (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .bus_clk(link.bus_clk), .data_valid_n(link.data_valid_n), .data_n(link.data_n),
        .data_invert_n(link.data_invert_n), .data_strobe_pos_n(link.data_strobe_pos_n),
        .data_strobe_neg_n(link.data_strobe_neg_n));
    // ********************************
    // Expectation helpers
    // ********************************
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // Group to be sent inverted: more than half its bits set
    function automatic logic [3:0] exp_inv(input logic [63:0] w);
        for (int g = 0; g < 4; g++) exp_inv[g] = $countones(w[16*g+:16]) > 8;
    endfunction
    // Pin levels are active low unless the group is inverted
    function automatic logic [63:0] exp_pins(input logic [63:0] w);
        logic [3:0] iv;
        iv = exp_inv(w);
        for (int g = 0; g < 4; g++) exp_pins[16*g+:16] = iv[g] ? w[16*g+:16] : ~w[16*g+:16];
    endfunction
    // ********************************
    // Monitors, sampled on settled values
    // ********************************
    always @(negedge core_clk_in) begin
        if (word_valid_out === 1'b1) begin
            if (exp_q.size() == 0) `CHECK("spurious word", 1'b0, 1'b1)
            else begin
                `CHECK("word_out", exp_q[0], word_out)
                void'(exp_q.pop_front());
            end
        end
        if (link.data_valid_n === 1'b0 && link.data_strobe_pos_n === 4'h0 && prev_pos !== 4'h0
            && wire_q.size() > 0) begin
            `CHECK("data_n", exp_pins(wire_q[0]), link.data_n)
            `CHECK("data_invert_n", ~exp_inv(wire_q[0]), link.data_invert_n)
            void'(wire_q.pop_front());
        end
        prev_pos = link.data_strobe_pos_n;
    end
    // ********************************
    // Drivers and closing
    // ********************************
    always #(fsb_pkg::CLK_PERIOD_NS / 2) core_clk_in = ~core_clk_in;
    // Valid stays up after a take, so back-to-back words keep it high with no low cycle between them
    task automatic send_word(input logic [63:0] w);
        int n = 0;
        @(negedge core_clk_in);
        word_in = w;
        word_valid_in = 1'b1;
        while (word_ready_out !== 1'b1 && n < 1000) begin
            @(negedge core_clk_in);
            n++;
        end
        @(posedge core_clk_in);
        exp_q.push_back(w);
        wire_q.push_back(w);
    endtask
    task automatic set_pins(input logic [3:0] v);
        @(negedge core_clk_in);
        {sleep_req_in, deep_sleep_in, deeper_sleep_in, n_a_in} = v;
        repeat (SETTLE) @(negedge core_clk_in);
    endtask
    task automatic report_and_stop();
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Limit is several times the expected run of under 2000 core cycles
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        logic [63:0] w;
        repeat (16) @(posedge core_clk_in);
        @(negedge core_clk_in);
        reset_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
        // Corners, then random words; bursts fill the buffer, gaps make idle clocks
        for (int i = 0; i < 48; i++) begin
            seed = xs(seed);
            w[31:0] = seed;
            seed = xs(seed);
            w[63:32] = seed;
            if (i < 4) w = CORNER[i];
            send_word(w);
            if (seed[1:0] == 2'h0) begin
                @(negedge core_clk_in);
                word_valid_in = 1'b0;
                repeat (seed[4:2]) @(negedge core_clk_in);
            end
        end
        @(negedge core_clk_in);
        word_valid_in = 1'b0;
        for (int n = 0; n < 2000 && exp_q.size() > 0; n++) @(negedge core_clk_in);
        `CHECK("words left", 0, exp_q.size())
        // Low-power steps, ignored requests and deferral report
        for (int i = 0; i < 7; i++) begin
            set_pins(PIN_TAB[i]);
            `CHECK("power_state_out", PWR_TAB[i], power_state_out)
            `CHECK("lite power state", (PWR_TAB[i] > 4'h2) ? 4'h2 : PWR_TAB[i], pwr_min)
            `CHECK("mid power state", (PWR_TAB[i] == 4'h8) ? 4'h4 : PWR_TAB[i], pwr_mid)
            `CHECK("deferred_out", PIN_TAB[i][0], deferred_out)
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
